// file: pkg/reset_seq_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef RESET_SEQ_REGS_SVH
`define RESET_SEQ_REGS_SVH

// register byte offsets
`define RS_OFS_CTRL 8'h00
`define RS_OFS_EVT 8'h04
`define RS_OFS_MASK 8'h08
`define RS_OFS_STATE 8'h0C
`define RS_OFS_KEEP 8'h10

// control fields
`define RS_CTRL_MODE_LO 0
`define RS_CTRL_MODE_HI 1
`define RS_CTRL_FALL 2
`define RS_CTRL_RST 8'h04

// event bits: power-on, master clear, watchdog, wake, release
`define RS_EVT_W 5
`define RS_MASK_RST 5'h00

// timing
`define RS_CLK_PERIOD_NS 25
`define RS_POWER_UP_TIMER_TIME_MS 96
`define RS_POWER_UP_TIMER_CYCLES ((`RS_POWER_UP_TIMER_TIME_MS * 1000000) / `RS_CLK_PERIOD_NS)
`define RS_OST_COUNT 1024

// program counter values
`define RS_PC_RESET 16'h0000
`define RS_INT_VECTOR 16'h0020

`endif

// file: pkg/reset_seq_pkg.sv
// types shared by the reset sequencer
package reset_seq_pkg;
    typedef enum logic [1:0] {
        osc_crystal, osc_low_freq, osc_ext_clock, osc_rc
    } osc_mode_e;

    typedef enum logic [2:0] {
        st_por, st_wait_master_clear_n, st_timing, st_run, st_master_clear_n_hold,
        st_sleep, st_ost
    } seq_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } bus_req_s;

    typedef struct packed {
        logic ale;
        logic oe_n;
        logic wr_n;
    } strobe_s;
endpackage : reset_seq_pkg

// file: core/reset_timeout_sequencer.sv
// reset source sequencer with power-up and oscillator start-up timers
// Contract
// - tell apart power-on, clear, watchdog, sleep cases
// - most resets initialise registers, sleep watchdog not
// - some registers are never reset
// - phase clock frozen in first phase during reset
// - external bus: latch strobe low, others high
// - hold reset until supply trips; falling supply resets
// - power-up timer counts 96 ms holding reset
// - start-up timer counts 1024 oscillator cycles
// - start-up count only crystal modes, power-on, wake
// - count oscillator pulses once amplitude is valid
// - both timers start together, release after both
// - first clear rising edge starts time-out
// - time-out and power-down flags per event
// - every reset loads program counter with zero
// - interrupt wake resumes at saved pc plus one
// - cpu status bits per wake and sleep watchdog
// - wake with interrupts enabled loads interrupt vector
`include "reset_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_sequencer #(
    parameter int POWER_UP_TIMER_CYCLES = `RS_POWER_UP_TIMER_CYCLES,
    parameter int OST_COUNT = `RS_OST_COUNT
) (
    // clock and block reset
    input wire logic clk,
    input wire logic rst,
    // pins from outside the clock domain
    input wire logic por_detect,
    input wire logic master_clear_n,
    input wire logic osc_input_pin,
    input wire logic osc_amp_ok,
    // events and levels from the core
    input wire logic wdt_timeout,
    input wire logic wake_int,
    input wire logic sleep_req,
    input wire logic watchdog_clear_instr,
    input wire logic global_int_disable,
    input wire logic [15:0] sleep_pc,
    input wire logic ext_exec_mode,
    input wire reset_seq_pkg::strobe_s cpu_strobe,
    // register port
    input wire reset_seq_pkg::bus_req_s bus,
    output logic [31:0] rdata,
    output logic irq,
    // reset results
    output logic core_reset,
    output logic reg_init,
    output logic [1:0] phase,
    output logic [15:0] pc,
    output logic pc_load,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic [3:0] cpu_status_reg,
    output reset_seq_pkg::strobe_s strobe
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] por_r, master_clear_n_r, osc_r, amp_r;
    logic por_q, master_clear_n_q, osc_q, amp_q, master_clear_n_prev_q, osc_prev_q;
    logic master_clear_n_rise, osc_edge;

    // three flops; level moves once second and third agree
    always_ff @(posedge clk) begin
        if (rst) begin
            por_r <= 3'h0;
            master_clear_n_r <= 3'h0;
            osc_r <= 3'h0;
            amp_r <= 3'h0;
            por_q <= 1'b0;
            master_clear_n_q <= 1'b0;
            osc_q <= 1'b0;
            amp_q <= 1'b0;
        end else begin
            por_r <= {por_r[1:0], por_detect};
            master_clear_n_r <= {master_clear_n_r[1:0], master_clear_n};
            osc_r <= {osc_r[1:0], osc_input_pin};
            amp_r <= {amp_r[1:0], osc_amp_ok};
            if (por_r[1] == por_r[2]) por_q <= por_r[2];
            if (master_clear_n_r[1] == master_clear_n_r[2]) master_clear_n_q <= master_clear_n_r[2];
            if (osc_r[1] == osc_r[2]) osc_q <= osc_r[2];
            if (amp_r[1] == amp_r[2]) amp_q <= amp_r[2];
        end
    end

    // edge detectors on the filtered levels
    always_ff @(posedge clk) begin
        if (rst) begin
            master_clear_n_prev_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            master_clear_n_prev_q <= master_clear_n_q;
            osc_prev_q <= osc_q;
        end
    end

    assign master_clear_n_rise = master_clear_n_q & ~master_clear_n_prev_q;
    assign osc_edge = osc_q & ~osc_prev_q & amp_q;

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] ctrl_q;
    logic [4:0] evt_q, mask_q, evt_set;
    logic [31:0] keep_q;
    reset_seq_pkg::osc_mode_e mode;
    logic xtal, fall_en;

    assign mode = reset_seq_pkg::osc_mode_e'(ctrl_q[`RS_CTRL_MODE_HI:
                                                   `RS_CTRL_MODE_LO]);
    assign xtal = (mode == reset_seq_pkg::osc_crystal) ||
                  (mode == reset_seq_pkg::osc_low_freq);
    assign fall_en = ctrl_q[`RS_CTRL_FALL];

    // control and mask writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `RS_CTRL_RST;
            mask_q <= `RS_MASK_RST;
        end else if (bus.we) begin
            if (bus.addr == `RS_OFS_CTRL) ctrl_q <= bus.wdata[7:0];
            if (bus.addr == `RS_OFS_MASK) mask_q <= bus.wdata[4:0];
        end
    end

    // scratch word untouched by every reset
    always_ff @(posedge clk) begin
        if (bus.we && bus.addr == `RS_OFS_KEEP) keep_q <= bus.wdata;
    end

    // sticky events, write one to clear, a new event wins
    always_ff @(posedge clk) begin
        if (rst) begin
            evt_q <= 5'h00;
        end else begin
            evt_q <= (evt_q & ~((bus.we && bus.addr == `RS_OFS_EVT) ?
                      bus.wdata[4:0] : 5'h00)) | evt_set;
        end
    end

    // interrupt output
    always_ff @(posedge clk) begin
        if (rst) irq <= 1'b0;
        else irq <= |(evt_q & mask_q);
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    reset_seq_pkg::seq_state_e state_q, state_d;
    logic [$clog2(POWER_UP_TIMER_CYCLES + 1) - 1:0] power_up_timer_cnt_q;
    logic [$clog2(OST_COUNT + 1) - 1:0] ost_cnt_q;
    logic power_up_timer_done, ost_done, hold_d, wdt_pulse_q, ost_need_q;
    logic vec_pend_q;

    assign power_up_timer_done = power_up_timer_cnt_q ==
                       ($bits(power_up_timer_cnt_q))'(POWER_UP_TIMER_CYCLES);
    assign ost_done = ost_cnt_q == ($bits(ost_cnt_q))'(OST_COUNT);

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            reset_seq_pkg::st_por: begin
                if (por_q) state_d = reset_seq_pkg::st_wait_master_clear_n;
            end
            reset_seq_pkg::st_wait_master_clear_n: begin
                // filtered level starts low: high means first rise seen
                if (master_clear_n_rise || master_clear_n_q) begin
                    state_d = reset_seq_pkg::st_timing;
                end
            end
            reset_seq_pkg::st_timing: begin
                if (power_up_timer_done && (ost_done || !xtal)) begin
                    state_d = reset_seq_pkg::st_run;
                end
            end
            reset_seq_pkg::st_run: begin
                if (!master_clear_n_q) state_d = reset_seq_pkg::st_master_clear_n_hold;
                else if (sleep_req) state_d = reset_seq_pkg::st_sleep;
            end
            reset_seq_pkg::st_master_clear_n_hold: begin
                if (master_clear_n_q) begin
                    state_d = (ost_need_q && xtal) ?
                              reset_seq_pkg::st_ost : reset_seq_pkg::st_run;
                end
            end
            reset_seq_pkg::st_sleep: begin
                if (!master_clear_n_q) state_d = reset_seq_pkg::st_master_clear_n_hold;
                else if (wdt_timeout || wake_int) begin
                    state_d = xtal ? reset_seq_pkg::st_ost :
                              reset_seq_pkg::st_run;
                end
            end
            reset_seq_pkg::st_ost: begin
                if (ost_done) state_d = reset_seq_pkg::st_run;
            end
            default: state_d = reset_seq_pkg::st_por;
        endcase
        if (fall_en && !por_q) state_d = reset_seq_pkg::st_por;
    end

    // core held in reset outside run and sleep, and for a running watchdog
    assign hold_d = !(state_d == reset_seq_pkg::st_run ||
                      state_d == reset_seq_pkg::st_sleep) ||
                    (state_q == reset_seq_pkg::st_run && wdt_timeout &&
                     state_d == reset_seq_pkg::st_run);

    // state register
    always_ff @(posedge clk) begin
        if (rst) state_q <= reset_seq_pkg::st_por;
        else state_q <= state_d;
    end

    // power-up timer, runs only while timing
    always_ff @(posedge clk) begin
        if (rst || state_q != reset_seq_pkg::st_timing) begin
            power_up_timer_cnt_q <= '0;
        end else if (!power_up_timer_done) begin
            power_up_timer_cnt_q <= power_up_timer_cnt_q + 1'b1;
        end
    end

    // start-up timer counts valid oscillator pulses
    always_ff @(posedge clk) begin
        if (rst || !(state_q == reset_seq_pkg::st_timing ||
                     state_q == reset_seq_pkg::st_ost)) begin
            ost_cnt_q <= '0;
        end else if (osc_edge && !ost_done) begin
            ost_cnt_q <= ost_cnt_q + 1'b1;
        end
    end

    // clear seen in sleep still owes a start-up count
    always_ff @(posedge clk) begin
        if (rst) ost_need_q <= 1'b0;
        else if (state_q == reset_seq_pkg::st_sleep && !master_clear_n_q)
            ost_need_q <= 1'b1;
        else if (state_q == reset_seq_pkg::st_run) ost_need_q <= 1'b0;
    end

    // ************************************************************
    // reset outputs, flags and program counter
    // ************************************************************
    logic run_entry, wdt_run, wdt_slp, wake_slp, master_clear_n_slp, master_clear_n_run;

    assign run_entry = state_d == reset_seq_pkg::st_run &&
                       state_q != reset_seq_pkg::st_run;
    assign master_clear_n_run = state_q == reset_seq_pkg::st_run && !master_clear_n_q;
    assign master_clear_n_slp = state_q == reset_seq_pkg::st_sleep && !master_clear_n_q;
    assign wdt_run = state_q == reset_seq_pkg::st_run && master_clear_n_q &&
                     wdt_timeout;
    assign wdt_slp = state_q == reset_seq_pkg::st_sleep && master_clear_n_q &&
                     wdt_timeout;
    assign wake_slp = state_q == reset_seq_pkg::st_sleep && master_clear_n_q &&
                      !wdt_timeout && wake_int;
    assign evt_set = {run_entry, wake_slp, wdt_run | wdt_slp,
                      master_clear_n_run | master_clear_n_slp,
                      state_d == reset_seq_pkg::st_por &&
                      state_q != reset_seq_pkg::st_por};

    // hold, register init and phase freeze
    always_ff @(posedge clk) begin
        if (rst) begin
            core_reset <= 1'b1;
            reg_init <= 1'b1;
            phase <= 2'h0;
        end else begin
            core_reset <= hold_d;
            if (state_d == reset_seq_pkg::st_por || master_clear_n_run || master_clear_n_slp ||
                wdt_run)
                reg_init <= 1'b1;
            else if (!hold_d || wdt_slp) reg_init <= 1'b0;
            phase <= hold_d ? 2'h0 : phase + 2'h1;
        end
    end

    // external bus strobes forced safe during reset when ext_exec_mode is set
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe <= '{ale: 1'b0, oe_n: 1'b1, wr_n: 1'b1};
        end else if (hold_d && ext_exec_mode) begin
            strobe <= '{ale: 1'b0, oe_n: 1'b1, wr_n: 1'b1};
        end else begin
            strobe <= cpu_strobe;
        end
    end

    // cause flags and cpu status bits
    always_ff @(posedge clk) begin
        if (rst || state_d == reset_seq_pkg::st_por) begin
            {timeout_flag_n, powerdown_flag_n} <= 2'h3;
            cpu_status_reg <= 4'hF;
        end else if (master_clear_n_slp) begin
            {timeout_flag_n, powerdown_flag_n} <= 2'h2;
            cpu_status_reg <= 4'hE;
        end else if (master_clear_n_run || (watchdog_clear_instr &&
                     state_q == reset_seq_pkg::st_run)) begin
            {timeout_flag_n, powerdown_flag_n} <= 2'h3;
            cpu_status_reg <= {2'h3, 2'h3};
        end else if (wdt_run) begin
            {timeout_flag_n, powerdown_flag_n} <= 2'h1;
            cpu_status_reg <= 4'hD;
        end else if (wdt_slp) begin
            {timeout_flag_n, powerdown_flag_n} <= 2'h0;
            cpu_status_reg <= 4'hC;
        end else if (wake_slp) begin
            {timeout_flag_n, powerdown_flag_n} <= 2'h2;
            cpu_status_reg <= {1'b1, global_int_disable, 2'h2};
        end
    end

    // program counter and load strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            pc <= `RS_PC_RESET;
            pc_load <= 1'b0;
            vec_pend_q <= 1'b0;
            wdt_pulse_q <= 1'b0;
        end else begin
            pc_load <= run_entry || wdt_run ||
                       (vec_pend_q && phase == 2'h3);
            wdt_pulse_q <= wdt_run;
            if (wake_slp) begin
                pc <= sleep_pc + 16'h0001;
                vec_pend_q <= !global_int_disable;
            end else if (state_d == reset_seq_pkg::st_por || master_clear_n_run ||
                         master_clear_n_slp || wdt_run || wdt_slp) begin
                pc <= `RS_PC_RESET;
                vec_pend_q <= 1'b0;
            end else if (vec_pend_q && phase == 2'h3 &&
                         state_q == reset_seq_pkg::st_run) begin
                pc <= `RS_INT_VECTOR;
                vec_pend_q <= 1'b0;
            end
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0;
        end else if (bus.re) begin
            case (bus.addr)
                `RS_OFS_CTRL: rdata <= {24'h0, ctrl_q};
                `RS_OFS_EVT: rdata <= {27'h0, evt_q};
                `RS_OFS_MASK: rdata <= {27'h0, mask_q};
                `RS_OFS_STATE: rdata <= {16'h0, 5'h0, state_q,
                                         cpu_status_reg, timeout_flag_n,
                                         powerdown_flag_n, core_reset,
                                         reg_init};
                `RS_OFS_KEEP: rdata <= keep_q;
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_PHASE_HOLD: assert property (@(posedge clk) disable iff (rst)
        core_reset |-> phase == 2'h0)
        else $error("phase moved during reset");

    AST_BUS_SAFE: assert property (@(posedge clk) disable iff (rst)
        core_reset && $past(ext_exec_mode) |->
        !strobe.ale && strobe.oe_n && strobe.wr_n)
        else $error("bus strobes not safe in reset");

    AST_POR_HOLD: assert property (@(posedge clk) disable iff (rst)
        state_q == reset_seq_pkg::st_por |=> core_reset)
        else $error("released while supply low");

    AST_BOTH_TIMERS: assert property (@(posedge clk) disable iff (rst)
        state_q == reset_seq_pkg::st_timing &&
        state_d == reset_seq_pkg::st_run |->
        power_up_timer_done && (ost_done || !xtal))
        else $error("power-up released early");

    AST_OST_MODE: assert property (@(posedge clk) disable iff (rst)
        state_q == reset_seq_pkg::st_ost |-> xtal)
        else $error("start-up count in non-crystal mode");

    AST_WDT_SLEEP: assert property (@(posedge clk) disable iff (rst)
        wdt_slp && !(fall_en && !por_q) |=>
        pc == 16'h0000 && cpu_status_reg == 4'hC &&
        !timeout_flag_n && !powerdown_flag_n)
        else $error("sleep watchdog result wrong");

    AST_WAKE_PC: assert property (@(posedge clk) disable iff (rst)
        wake_slp && !(fall_en && !por_q) |=>
        pc == $past(sleep_pc) + 16'h0001 &&
        cpu_status_reg == {1'b1, $past(global_int_disable), 2'h2})
        else $error("wake pc or status wrong");

    AST_MASTER_CLEAR_N_SLEEP: assert property (@(posedge clk) disable iff (rst)
        master_clear_n_slp && !(fall_en && !por_q) |=>
        timeout_flag_n && !powerdown_flag_n && reg_init)
        else $error("clear in sleep flags wrong");

    AST_WDT_RUN: assert property (@(posedge clk) disable iff (rst)
        wdt_run && !(fall_en && !por_q) |=>
        core_reset && pc_load && !timeout_flag_n && powerdown_flag_n
        ##1 !core_reset)
        else $error("running watchdog reset wrong");

endmodule : reset_timeout_sequencer

`default_nettype wire

// file: sim/clear_osc_model.sv
// partner model: clear pin driver and crystal oscillator
`timescale 1ns/1ps
`default_nettype none

module clear_osc_model (
    // clock and controls from the bench
    input wire logic clk,
    input wire logic supply_ok,
    input wire logic hold_clear,
    input wire logic osc_on,
    // pins toward the sequencer
    output logic master_clear_n,
    output logic osc_input_pin,
    output logic osc_amp_ok
);
    logic [5:0] cnt_q;
    logic amp_q;

    // clear pin kept low until the supply is valid
    assign master_clear_n = supply_ok & ~hold_clear;

    // crystal: stands still when off, swings at once, amplitude flag set once the count reaches 32
    always_ff @(posedge clk) begin
        if (!osc_on) begin
            cnt_q <= 6'h00;
            amp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q[5]) begin
                amp_q <= 1'b1;
            end
        end
    end

    // eight clocks per oscillator period, slow enough for the filter
    assign osc_input_pin = cnt_q[2];
    assign osc_amp_ok = amp_q;
endmodule : clear_osc_model
`default_nettype wire

// file: sim/reset_timeout_sequencer_tb.sv
// self-checking bench for the reset sequencer
`include "reset_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_sequencer_tb;
    localparam int POWER_UP_TIMER = 20;
    localparam int OSTC = 8;
    logic clk, rst, supply_ok, hold_clear, osc_on;
    logic clear_n, osc_pin, amp_ok;
    logic wdt_timeout, wake_int, sleep_req, wd_clr, gid, ext_exec_mode;
    logic [15:0] sleep_pc, pc;
    reset_seq_pkg::strobe_s cpu_strobe, strobe;
    reset_seq_pkg::bus_req_s bus;
    logic [31:0] rdata, got, keep;
    logic irq, core_reset, reg_init, pc_load, to_n, pd_n;
    logic [1:0] phase;
    logic [3:0] status;
    int err_count, compares, seed, i, n;

    reset_timeout_sequencer #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER), .OST_COUNT(OSTC)) dut (
        .clk(clk), .rst(rst), .por_detect(supply_ok),
        .master_clear_n(clear_n), .osc_input_pin(osc_pin),
        .osc_amp_ok(amp_ok), .wdt_timeout(wdt_timeout),
        .wake_int(wake_int), .sleep_req(sleep_req),
        .watchdog_clear_instr(wd_clr), .global_int_disable(gid),
        .sleep_pc(sleep_pc), .ext_exec_mode(ext_exec_mode),
        .cpu_strobe(cpu_strobe), .bus(bus), .rdata(rdata), .irq(irq),
        .core_reset(core_reset), .reg_init(reg_init), .phase(phase),
        .pc(pc), .pc_load(pc_load), .timeout_flag_n(to_n),
        .powerdown_flag_n(pd_n), .cpu_status_reg(status),
        .strobe(strobe)
    );

    clear_osc_model partner (
        .clk(clk), .supply_ok(supply_ok), .hold_clear(hold_clear),
        .osc_on(osc_on), .master_clear_n(clear_n),
        .osc_input_pin(osc_pin), .osc_amp_ok(amp_ok)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [3:0] wake_status(input logic dis);
        return {1'b1, dis, 2'b10};
    endfunction : wake_status

    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // k: 0 wake, 1 sleep, 2 watchdog, 3 watchdog clear
    task automatic ev(input int k);
        @(posedge clk);
        {wake_int, sleep_req, wdt_timeout, wd_clr} <= 4'h8 >> k;
        @(posedge clk);
        {wake_int, sleep_req, wdt_timeout, wd_clr} <= 4'h0;
        #1;
    endtask : ev

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= {a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= {a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask : rd

    task automatic wait_rst(input logic lvl, output int cyc);
        for (cyc = 0; cyc < 3000 && core_reset !== lvl; cyc++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_rst

    // ****************************************
    // clock, watchdog and main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        seed = 32'h49ae458f;
        {rst, gid, ext_exec_mode} = 3'b111;
        {supply_ok, hold_clear, osc_on} = 3'b000;
        {wake_int, sleep_req, wdt_timeout, wd_clr} = 4'h0;
        sleep_pc = 16'h0000;
        cpu_strobe = 3'b100;
        bus = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check("strobe", strobe, 3'b011);
        rd(`RS_OFS_CTRL, got);
        check("ctrl", got, `RS_CTRL_RST);
        rd(`RS_OFS_MASK, got);
        check("mask", got, `RS_MASK_RST);
        rd(8'h20, got);
        check("unmapped", got, 32'h0000_0000);
        // supply up, crystal silent: start-up count cannot finish
        @(posedge clk) supply_ok <= 1'b1;
        repeat (POWER_UP_TIMER + 60) @(posedge clk);
        #1 check("held", core_reset, 1'b1);
        check("phase", phase, 2'h0);
        @(posedge clk) osc_on <= 1'b1;
        wait_rst(1'b0, n);
        check("ost", n >= OSTC * 8 && n < 3000, 1'b1);
        check("pc", pc, `RS_PC_RESET);
        check("status", status, 4'hF);
        check("strobe run", strobe, 3'b100);
        // watchdog in run, with interrupt
        wr(`RS_OFS_EVT, 32'h0000_001F);
        wr(`RS_OFS_MASK, 32'h0000_0004);
        keep = $random(seed);
        wr(`RS_OFS_KEEP, keep);
        ev(2);
        check("wdt flags", {to_n, pd_n}, 2'b01);
        check("wdt load", {pc_load, reg_init}, 2'b11);
        check("wdt pc", pc, `RS_PC_RESET);
        repeat (2) @(posedge clk);
        #1 check("irq", irq, 1'b1);
        wr(`RS_OFS_EVT, 32'h0000_0004);
        repeat (2) @(posedge clk);
        #1 check("irq clr", irq, 1'b0);
        ev(3);
        check("clr flags", {to_n, pd_n}, 2'b11);
        // clear pin pulled low while running
        @(posedge clk) hold_clear <= 1'b1;
        wait_rst(1'b1, n);
        check("clr init", {reg_init, to_n, pd_n}, 3'b111);
        @(posedge clk) hold_clear <= 1'b0;
        wait_rst(1'b0, n);
        rd(`RS_OFS_KEEP, got);
        check("keep", got, keep);
        // interrupt wake with random saved pc, no start-up count
        wr(`RS_OFS_CTRL, 32'h0000_0006);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            sleep_pc <= 16'($random(seed));
            gid <= (i == 0) ? 1'b0 : 1'($random(seed));
            ev(1);
            ev(0);
            check("wake pc", pc, 16'(sleep_pc + 16'h0001));
            check("wake flags", {to_n, pd_n}, 2'b10);
            check("wake st", status, wake_status(gid));
            for (n = 0; n < 12 && !gid && pc !== `RS_INT_VECTOR; n++) begin
                @(posedge clk);
                #1;
            end
            check("vector", pc, gid ? 16'(sleep_pc + 16'h0001) :
                  `RS_INT_VECTOR);
            wait_rst(1'b0, n);
        end
        // watchdog in sleep, crystal mode
        wr(`RS_OFS_CTRL, 32'h0000_0004);
        ev(1);
        ev(2);
        check("sw flags", {to_n, pd_n, reg_init}, 3'b000);
        check("sw st", status, 4'hC);
        check("sw pc", pc, `RS_PC_RESET);
        wait_rst(1'b0, n);
        // clear in sleep
        ev(1);
        @(posedge clk) hold_clear <= 1'b1;
        wait_rst(1'b1, n);
        check("sc flags", {to_n, pd_n, reg_init}, 3'b101);
        @(posedge clk) hold_clear <= 1'b0;
        wait_rst(1'b0, n);
        // supply falls while running
        @(posedge clk) supply_ok <= 1'b0;
        wait_rst(1'b1, n);
        check("fall", n < 12, 1'b1);
        check("fall st", strobe, 3'b011);
        tally_and_finish();
    end
endmodule : reset_timeout_sequencer_tb
`default_nettype wire
